// ### cvt_pkg.sv
package cvt_pkg;

  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned CODE_W   = 14;

  // command codes of the four voltage results
  localparam logic [7:0] CMD_CHAN_ONE   = 8'h32;
  localparam logic [7:0] CMD_CHAN_TWO   = 8'h36;
  localparam logic [7:0] CMD_CHAN_THREE = 8'h3a;
  localparam logic [7:0] CMD_CHAN_FOUR  = 8'h3e;

  localparam logic [15:0] VOLT_RESET   = 16'h0000;
  localparam logic [15:0] VOLT_OFF     = 16'h0000;
  localparam logic [7:0]  UNMAPPED_BYTE = 8'h00;
  localparam int unsigned CODE_LSB     = 0;
  localparam int unsigned CODE_MSB     = 13;
  localparam int unsigned HI_BYTE_LSB  = 8;

  // scaling, in microvolts: step 3.662 mV, full scale 60 V
  localparam longint unsigned VOLTAGE_LSB_WEIGHT_UV = 3662;
  localparam longint unsigned FULL_SCALE_UV         = 60000000;

  // byte-level request from the serial command engine
  typedef struct packed {
    logic       cmd_wr;   // command code byte received
    logic [7:0] cmd_code;
    logic       rd_req;   // next data byte wanted
    logic       wr_req;   // data byte written by the host
    logic [7:0] wr_data;
  } cvt_req_t;

  // answer back to the engine
  typedef struct packed {
    logic       rd_valid;
    logic [7:0] rd_data;
    logic       hit;      // current command is a voltage register
  } cvt_rsp_t;

  // raw conversion input of one channel
  typedef struct packed {
    logic              done;
    logic [CODE_W-1:0] rail;
    logic [CODE_W-1:0] drain;
  } cvt_raw_t;

endpackage

// ### cvt_diff.sv
`timescale 1ns/1ns
`default_nettype none
module cvt_diff
  import cvt_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire cvt_raw_t          raw,
  output logic                   done,
  output logic [CODE_W-1:0]      code
);

  typedef struct packed {
    logic              done;
    logic [CODE_W-1:0] code;
  } cvt_diff_st_t;

  cvt_diff_st_t st;
  cvt_diff_st_t next_st;

  // rail minus drain; a drain above the rail would wrap, so clamp to zero
  always_comb begin
    next_st      = st;
    next_st.done = raw.done;
    if (raw.done) begin
      if (raw.drain > raw.rail) begin
        next_st.code = '0;
      end else begin
        next_st.code = raw.rail - raw.drain; // [R6]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done = st.done;
  assign code = st.code;

  a_diff_value : assert property (@(posedge core_clk) disable iff (srst) // [R6]
    raw.done && raw.rail >= raw.drain |=> code == $past(raw.rail) - $past(raw.drain))
    else $error("difference code wrong");

endmodule // cvt_diff
`default_nettype wire

// ### cvt_top.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// (R1) channel one result at command 32h, channel two at 36h, both read only.
// (R2) channel three result at command 3Ah, channel four at 3Eh, read only.
// (R3) two-byte read, low byte first; host reads both; writes change nothing.
// (R4) 14-bit code in bits 13-0, top two bits zero, all reset to zero.
// (R5) code times 3.662 mV gives the voltage, 60 V full scale.
// (R6) conversion measures supply rail minus the channel drain.
// (R7) a channel that is off reads 0000 whatever was measured before.
// (R8) high byte captured with the low byte, so a read is one sample.
module cvt_top
  import cvt_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                srst,
  input  wire cvt_req_t            req,
  output cvt_rsp_t                 rsp,
  input  wire logic [CODE_W-1:0]   supply_rail_pin,
  input  wire logic [NUM_CHAN-1:0][CODE_W-1:0] channel_drain_pin,
  input  wire logic [NUM_CHAN-1:0] conv_done,
  input  wire logic [NUM_CHAN-1:0] chan_on
);

  // whole state of the reader, registered in one place
  typedef struct packed {
    logic [7:0]                        cmd_ptr;
    logic                              byte_hi;
    logic [15:0]                       snap;
    logic [7:0]                        rd_data;
    logic                              rd_valid;
    logic [NUM_CHAN-1:0][CODE_W-1:0]   result;
  } cvt_st_t;

  cvt_st_t st;
  cvt_st_t next_st;

  logic [NUM_CHAN-1:0]             diff_done;
  logic [NUM_CHAN-1:0][CODE_W-1:0] diff_code;
  logic [NUM_CHAN-1:0][15:0]       view;

  // one subtractor per channel; off channels read as zero
  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_chan
      cvt_raw_t raw;
      // one assignment, so the struct has a single driver
      assign raw = '{done: conv_done[g], rail: supply_rail_pin, drain: channel_drain_pin[g]};
      cvt_diff u_diff (
        .core_clk (core_clk),
        .srst     (srst),
        .raw      (raw),
        .done     (diff_done[g]),
        .code     (diff_code[g])
      );
      // forced at read time, so a stale sample never leaks
      assign view[g] = chan_on[g] ? {2'b00, st.result[g]} : VOLT_OFF; // [R7] [R4]
      // a conversion lands one edge after the subtractor shows it, if powered then
      a_result_store : assert property (@(posedge core_clk) disable iff (srst) // [R6]
        diff_done[g] |=> st.result[g] == ($past(chan_on[g]) ? $past(diff_code[g])
                                                           : $past(st.result[g])))
        else $error("stored result wrong");
    end
  endgenerate

  logic       sel_hit;
  logic [1:0] sel_idx;

  // command decode
  always_comb begin
    sel_hit = 1'b1;
    sel_idx = 2'd0;
    unique case (st.cmd_ptr)
      CMD_CHAN_ONE:   sel_idx = 2'd0; // [R1]
      CMD_CHAN_TWO:   sel_idx = 2'd1; // [R1]
      CMD_CHAN_THREE: sel_idx = 2'd2; // [R2]
      CMD_CHAN_FOUR:  sel_idx = 2'd3; // [R2]
      default:        sel_hit = 1'b0;
    endcase
  end

  // next state
  always_comb begin
    next_st          = st;
    next_st.rd_valid = 1'b0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      // only powered conversions are kept; result scale is one step per code
      if (diff_done[i] && chan_on[i]) begin
        next_st.result[i] = diff_code[i]; // [R5]
      end
    end
    if (req.cmd_wr) begin
      next_st.cmd_ptr = req.cmd_code;
      next_st.byte_hi = 1'b0;
    end else if (req.rd_req) begin
      next_st.rd_valid = 1'b1;
      if (!sel_hit) begin
        next_st.rd_data = UNMAPPED_BYTE;
      end else if (!st.byte_hi) begin
        next_st.snap    = view[sel_idx]; // [R8]
        next_st.rd_data = view[sel_idx][7:0]; // [R3]
        next_st.byte_hi = 1'b1;
      end else begin
        next_st.rd_data = st.snap[15:HI_BYTE_LSB]; // [R3] [R8]
        next_st.byte_hi = 1'b0;
      end
    end
    // host data writes are acknowledged upstream and ignored here [R3]
  end

  // single register stage for the whole reader state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0; // [R4]
    end else begin
      st <= next_st;
    end
  end

  // responses straight from flip-flops; hit follows the registered pointer
  assign rsp.rd_valid = st.rd_valid;
  assign rsp.rd_data  = st.rd_data;
  assign rsp.hit      = sel_hit;

  // a data read while the pointer names a voltage register, per byte phase
  sequence s_low_read;
    req.rd_req && !req.cmd_wr && sel_hit && !st.byte_hi;
  endsequence

  sequence s_high_read;
    req.rd_req && !req.cmd_wr && sel_hit && st.byte_hi;
  endsequence

  // a read against a code that is not a voltage register
  sequence s_miss_read;
    req.rd_req && !req.cmd_wr && !sel_hit;
  endsequence

  // the low byte comes straight from the live view
  a_low_byte : assert property (@(posedge core_clk) disable iff (srst) // [R3]
    s_low_read |=> rsp.rd_valid && rsp.rd_data == $past(view[sel_idx][7:0]))
    else $error("low byte not first");

  // the low byte read also freezes the whole word for the high byte
  a_snap_on_low : assert property (@(posedge core_clk) disable iff (srst) // [R8]
    s_low_read |=> st.byte_hi && st.snap == $past(view[sel_idx]))
    else $error("word not captured at low byte");

  // gaps up to eight cycles are covered here; the bench never leaves a gap of more than six
  a_coherent_pair : assert property (@(posedge core_clk) disable iff (srst) // [R8]
    s_low_read ##[1:8] s_high_read |=> rsp.rd_data == $past(st.snap[15:8]))
    else $error("high byte not from low byte sample");

  // usual pair cadence: the high byte is the word as it stood at the low byte
  a_pair_sample : assert property (@(posedge core_clk) disable iff (srst) // [R8]
    s_low_read ##2 s_high_read |=> rsp.rd_data == $past(view[sel_idx][15:8], 3))
    else $error("high byte from a later sample");

  // the two spare bits can never be set
  a_top_bits_zero : assert property (@(posedge core_clk) disable iff (srst) // [R4]
    st.byte_hi |-> st.snap[15:14] == 2'b00)
    else $error("top bits of high byte set");

  // an off channel shows zero whatever it stored
  a_off_reads_zero : assert property (@(posedge core_clk) disable iff (srst) // [R7]
    (s_low_read and (!chan_on[sel_idx])) |=> rsp.rd_data == 8'h00 && st.snap == VOLT_OFF)
    else $error("off channel not zero");

  // command decode, channels one and two
  a_map_one_two : assert property (@(posedge core_clk) disable iff (srst) // [R1]
    (st.cmd_ptr == CMD_CHAN_ONE || st.cmd_ptr == CMD_CHAN_TWO) |->
      sel_hit && sel_idx == (st.cmd_ptr == CMD_CHAN_ONE ? 2'd0 : 2'd1))
    else $error("channel one/two decode wrong");

  // command decode, channels three and four
  a_map_three_four : assert property (@(posedge core_clk) disable iff (srst) // [R2]
    (st.cmd_ptr == CMD_CHAN_THREE || st.cmd_ptr == CMD_CHAN_FOUR) |->
      sel_hit && sel_idx == (st.cmd_ptr == CMD_CHAN_THREE ? 2'd2 : 2'd3))
    else $error("channel three/four decode wrong");

  // a data write is swallowed; only an earlier answer pulse may drop
  a_write_no_effect : assert property (@(posedge core_clk) disable iff (srst) // [R3]
    req.wr_req && !req.cmd_wr && !req.rd_req && diff_done == '0 |=>
      !rsp.rd_valid && $stable(st.cmd_ptr) && $stable(st.byte_hi) && $stable(st.snap)
      && $stable(st.rd_data) && $stable(st.result))
    else $error("write changed state");

  // the largest code stays inside the stated range
  a_full_scale : assert property (@(posedge core_clk) disable iff (srst) // [R5]
    s_low_read |=> (64'(st.snap) * VOLTAGE_LSB_WEIGHT_UV) <= FULL_SCALE_UV)
    else $error("voltage beyond full scale");

  // channel one keeps what its subtractor produced
  a_result_source : assert property (@(posedge core_clk) disable iff (srst) // [R6]
    diff_done[0] && chan_on[0] |=> st.result[0] == $past(diff_code[0]))
    else $error("result not taken from difference");

  // every answer comes from a taken read one edge before
  a_valid_pulse : assert property (@(posedge core_clk) disable iff (srst) // [R3]
    rsp.rd_valid |-> $past(req.rd_req) && !$past(req.cmd_wr))
    else $error("answer without a read");

  // an unmapped read answers zero and leaves the byte phase alone
  a_miss_read : assert property (@(posedge core_clk) disable iff (srst) // [R1] [R2]
    s_miss_read |=> rsp.rd_valid && rsp.rd_data == UNMAPPED_BYTE && $stable(st.byte_hi))
    else $error("unmapped read not zero");

  // the pair wraps, so the next read is a fresh low byte
  a_phase_wrap : assert property (@(posedge core_clk) disable iff (srst) // [R3]
    s_high_read |=> !st.byte_hi)
    else $error("byte phase did not wrap");

  // a command byte restarts the pair at the low byte
  a_cmd_restart : assert property (@(posedge core_clk) disable iff (srst) // [R3]
    req.cmd_wr |=> !st.byte_hi && st.cmd_ptr == $past(req.cmd_code))
    else $error("command did not restart pair");

  // reset leaves nothing to read; not disabled, reset is the trigger
  a_reset_clear : assert property (@(posedge core_clk) // [R4]
    srst |=> st.result == '0 && st.snap == '0 && !rsp.rd_valid && rsp.rd_data == 8'h00)
    else $error("state not cleared by reset");

endmodule // cvt_top
`default_nettype wire

// ### cvt_host.sv
`timescale 1ns/1ns
`default_nettype none
// host side of the command engine; every call starts just after a falling edge
module cvt_host
  import cvt_pkg::*;
(
  input  wire logic     core_clk,
  input  wire cvt_rsp_t rsp,
  output cvt_req_t      req
);
  initial req = '0;
  // command byte; code bus flipped afterwards so a stale code is never seen
  task automatic set_cmd(input logic [7:0] code);
    req.cmd_code = code;
    req.cmd_wr = 1'b1;
    @(negedge core_clk);
    req.cmd_wr = 1'b0;
    req.cmd_code = ~code;
    @(negedge core_clk);
  endtask
  // data byte write, which the device must ignore
  task automatic write_byte(input logic [7:0] data);
    req.wr_data = data;
    req.wr_req = 1'b1;
    @(negedge core_clk);
    req.wr_req = 1'b0;
    req.wr_data = ~data;
    @(negedge core_clk);
  endtask
  // one data byte; the answer stands for one cycle, so take it mid-cycle
  task automatic get_byte(output logic [7:0] b);
    req.rd_req = 1'b1;
    @(negedge core_clk);
    req.rd_req = 1'b0;
    b = (rsp.rd_valid === 1'b1) ? rsp.rd_data : 8'hxx;
    @(negedge core_clk);
  endtask
  // full register read: both bytes, low first, always taken whole
  task automatic read_reg(input logic [7:0] code, output logic [15:0] val);
    set_cmd(code);
    get_byte(val[7:0]);
    get_byte(val[15:8]);
  endtask
endmodule // cvt_host
`default_nettype wire

// ### cvt_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module cvt_top_tb
  import cvt_pkg::*;
;
  logic                        core_clk = 1'b0;
  logic                        srst = 1'b1;
  cvt_req_t                    req;
  cvt_rsp_t                    rsp;
  logic [CODE_W-1:0]           rail = '0;
  logic [NUM_CHAN-1:0][CODE_W-1:0] drain = '0;
  logic [NUM_CHAN-1:0]         conv_done = '0;
  logic [NUM_CHAN-1:0]         chan_on = '0;
  int                          num_errors = 0;
  int                          check_count = 0;
  logic [15:0]                 v;

  initial forever #25 core_clk = ~core_clk;

  cvt_top i_dut (.core_clk(core_clk), .srst(srst), .req(req), .rsp(rsp),
    .supply_rail_pin(rail), .channel_drain_pin(drain), .conv_done(conv_done),
    .chan_on(chan_on));
  cvt_host i_host (.core_clk(core_clk), .rsp(rsp), .req(req));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function automatic logic [7:0] cmd(input int i);
    return CMD_CHAN_ONE + 8'(4 * i);
  endfunction
  // one conversion pulse, then room for the two-cycle store
  task automatic conv(input int ch, input logic [13:0] r, input logic [13:0] d);
    rail = r;
    drain[ch] = d;
    conv_done[ch] = 1'b1;
    @(negedge core_clk);
    conv_done = '0;
    repeat (3) @(negedge core_clk);
  endtask
  // everything reads zero out of reset, unmapped code as well
  task automatic t_reset;
    for (int i = 0; i < 4; i++) begin
      i_host.read_reg(cmd(i), v);
      check(v, VOLT_RESET);
      check(16'(rsp.hit), 16'h0001);
    end
    i_host.read_reg(8'h34, v);
    check(v, 16'h0000);
    check(16'(rsp.hit), 16'h0000);
  endtask
  // reset in mid-run wipes a stored result of a powered channel
  task automatic t_rerst;
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    i_host.read_reg(CMD_CHAN_ONE, v);
    check(v, VOLT_RESET);
  endtask
  // rail minus drain, per channel, at its own command code
  task automatic t_codes;
    chan_on = 4'hf;
    for (int i = 0; i < 4; i++) begin
      conv(i, 14'h3fff, 14'(i * 14'h0123));
      i_host.read_reg(cmd(i), v);
      check(v, {2'b00, 14'h3fff - 14'(i * 14'h0123)});
    end
  endtask
  // channel off forces zero; conversions while off are dropped
  task automatic t_off;
    chan_on[1] = 1'b0;
    i_host.read_reg(CMD_CHAN_TWO, v);
    check(v, VOLT_OFF);
    conv(1, 14'h0100, 14'h0001);
    chan_on[1] = 1'b1;
    i_host.read_reg(CMD_CHAN_TWO, v);
    check(v, 16'h3edc);
  endtask
  // a write to the register leaves it as it was
  task automatic t_write;
    i_host.set_cmd(CMD_CHAN_ONE);
    i_host.write_byte(8'h00);
    i_host.write_byte(8'hff);
    i_host.read_reg(CMD_CHAN_ONE, v);
    check(v, 16'h3fff);
  endtask
  // new conversion between the two bytes must not tear the sample
  task automatic t_snap;
    i_host.set_cmd(CMD_CHAN_FOUR);
    i_host.get_byte(v[7:0]);
    conv(3, 14'h3fff, 14'h0000);
    i_host.get_byte(v[15:8]);
    check(v, 16'h3c96);
    i_host.read_reg(CMD_CHAN_FOUR, v);
    check(v, 16'h3fff);
  endtask

  initial begin
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    t_reset();
    t_codes();
    t_off();
    t_write();
    t_snap();
    t_rerst();
    final_report();
  end
endmodule // cvt_top_tb
`default_nettype wire
